// ---- src/cib_core.sv ----
// Execution of irq enable, increments, accumulator jump, trap and OR immediate
// Overview of operation
// - Global irq on sets the enable flag in one cycle.
// - Add one to register; result to accumulator or register; updates zero; one cycle.
// - Add one skip on zero stores result to accumulator or register per destination.
// - Zero result discards fetched next instruction, runs no-op, two cycles total.
// - Accumulator jump loads PC from page low bits and accumulator; two cycles.
// - Software trap pushes PC plus one, loads vector 0x001; three cycles.
// - OR immediate into accumulator, updates zero, one cycle.
`timescale 1ns/10ps
`include "cib_regs.svh"
module cib_core
   import cib_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Decoded instruction from fetch
   input wire logic i_instr_valid,
   input wire cib_instr_type i_instr,
   // Register file read data for i_instr.reg_addr
   input wire logic [7:0] i_reg_rdata,
   // Table page high register value
   input wire logic [7:0] i_table_page_high,
   // Register file write
   output cib_rf_write_type o_rf_write,
   // Stack push
   output cib_stack_push_type o_stack_push,
   // Architectural state
   output logic [7:0] o_acc,
   output logic o_zero_flag,
   output logic o_global_irq_enable_flag,
   output logic [10:0] o_pc,
   // Handshake: ready for next instruction, fetched word discarded
   output logic o_ready,
   output logic o_flush
);
   logic [7:0] acc_ff;
   logic [7:0] nxt_acc;
   logic zero_ff;
   logic nxt_zero;
   logic gie_ff;
   logic nxt_gie;
   logic [10:0] pc_ff;
   logic [10:0] nxt_pc;
   logic [1:0] busy_ff;
   logic [1:0] nxt_busy;
   logic flush_ff;
   logic nxt_flush;
   cib_rf_write_type rfw_ff;
   cib_rf_write_type nxt_rfw;
   cib_stack_push_type push_ff;
   cib_stack_push_type nxt_push;
   logic [7:0] alu_result;
   logic alu_zero;

   // Instruction is taken only when not stalled by a multi-cycle one
   wire logic take = i_instr_valid && (busy_ff == 2'h0);
   wire cib_op_type op = i_instr.op;
   wire logic is_irq_on = take && (op == CIB_OP_GLOBAL_IRQ_ON);
   wire logic is_inc = take && (op == CIB_OP_ADD_ONE_TO_REGISTER);
   wire logic is_incsz = take && (op == CIB_OP_ADD_ONE_SKIP_ON_ZERO);
   wire logic is_jump = take && (op == CIB_OP_JUMP_VIA_ACCUMULATOR);
   wire logic is_trap = take && (op == CIB_OP_SOFTWARE_TRAP);
   wire logic is_or = take && (op == CIB_OP_OR_IMMEDIATE_INTO_ACCUMULATOR);
   wire logic any_inc = is_inc || is_incsz;
   wire logic [10:0] pc_plus_one = 11'(pc_ff + 11'h001);
   wire logic [1:0] busy_dec = 2'(busy_ff - 2'h1);

   cib_alu u_alu
   (
      .i_reg_data(i_reg_rdata),
      .i_acc(acc_ff),
      .i_imm(i_instr.imm),
      .i_sel_or(is_or),
      .o_result(alu_result),
      .o_zero(alu_zero)
   );

   // Next-state selection for each instruction
   always_comb
   begin
      nxt_acc = acc_ff;
      nxt_zero = zero_ff;
      nxt_gie = gie_ff;
      nxt_pc = pc_ff;
      nxt_busy = (busy_ff != 2'h0) ? busy_dec : 2'h0;
      nxt_flush = 1'b0;
      nxt_rfw = '0;
      nxt_push = '0;
      if (take)
      begin
         nxt_pc = pc_plus_one;
      end
      if (is_irq_on)
      begin
         nxt_gie = 1'b1;
      end
      if (any_inc)
      begin
         nxt_zero = alu_zero;
         if (i_instr.dest_reg)
         begin
            nxt_rfw.we = 1'b1;
            nxt_rfw.addr = i_instr.reg_addr;
            nxt_rfw.data = alu_result;
         end
         else
         begin
            nxt_acc = alu_result;
         end
      end
      if (is_incsz && alu_zero)
      begin
         nxt_flush = 1'b1;
         nxt_pc = 11'(pc_ff + 11'h002);
         nxt_busy = 2'(`CIB_SKIP_CYCLES - `CIB_ONE_CYCLE);
      end
      if (is_jump)
      begin
         nxt_pc = {i_table_page_high[2:0], acc_ff};
         nxt_busy = 2'(`CIB_JUMP_CYCLES - `CIB_ONE_CYCLE);
      end
      if (is_trap)
      begin
         nxt_push.push = 1'b1;
         nxt_push.ret_addr = pc_plus_one;
         nxt_pc = `CIB_TRAP_VECTOR;
         nxt_busy = 2'(`CIB_TRAP_CYCLES - `CIB_ONE_CYCLE);
      end
      if (is_or)
      begin
         nxt_acc = alu_result;
         nxt_zero = alu_zero;
      end
   end

   // Architectural state registers
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         acc_ff <= `CIB_ACC_RESET;
         zero_ff <= 1'b0;
         gie_ff <= 1'b0;
         pc_ff <= `CIB_PC_RESET;
      end
      else
      begin
         acc_ff <= nxt_acc;
         zero_ff <= nxt_zero;
         gie_ff <= nxt_gie;
         pc_ff <= nxt_pc;
      end
   end

   // Sequencing and strobe registers
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         busy_ff <= 2'h0;
         flush_ff <= 1'b0;
         rfw_ff <= '0;
         push_ff <= '0;
      end
      else
      begin
         busy_ff <= nxt_busy;
         flush_ff <= nxt_flush;
         rfw_ff <= nxt_rfw;
         push_ff <= nxt_push;
      end
   end

   assign o_acc = acc_ff;
   assign o_zero_flag = zero_ff;
   assign o_global_irq_enable_flag = gie_ff;
   assign o_pc = pc_ff;
   assign o_rf_write = rfw_ff;
   assign o_stack_push = push_ff;
   assign o_flush = flush_ff;
   // Stall while a multi-cycle instruction finishes
   assign o_ready = (busy_ff == 2'h0);

   a_irq_on_sets: assert property (@(posedge i_core_clk) disable iff (i_rst) is_irq_on |=> gie_ff)
      else $error("irq enable flag not set");
   a_inc_to_acc: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_inc && !i_instr.dest_reg) |=> (acc_ff == 8'($past(i_reg_rdata) + 8'h01)) && !rfw_ff.we)
      else $error("increment to accumulator wrong");
   a_incsz_to_reg: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_incsz && i_instr.dest_reg) |=> rfw_ff.we && (rfw_ff.data == 8'($past(i_reg_rdata) + 8'h01)))
      else $error("skip increment write wrong");
   a_skip_two_cycles: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_incsz && alu_zero) |=> flush_ff && !o_ready ##1 o_ready)
      else $error("skip timing wrong");
   a_jump_target: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_jump |=> (pc_ff == {$past(i_table_page_high[2:0]), $past(acc_ff)}) && $stable(zero_ff) && !o_ready)
      else $error("jump target wrong");
   a_trap_vector: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_trap |=> push_ff.push && (pc_ff == 11'h001) && !o_ready ##1 !o_ready ##1 o_ready)
      else $error("trap sequence wrong");
   a_or_result: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_or |=> (acc_ff == ($past(acc_ff) | $past(i_instr.imm))) && o_ready)
      else $error("or immediate wrong");
   a_zero_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_or || any_inc) |=> (zero_ff == ($past(is_or) ? (($past(acc_ff) | $past(i_instr.imm)) == 8'h00)
      : ($past(i_reg_rdata) == 8'hff))))
      else $error("zero flag wrong");

   c_skip: cover property (@(posedge i_core_clk) disable iff (i_rst) is_incsz && alu_zero);
   c_trap: cover property (@(posedge i_core_clk) disable iff (i_rst) is_trap);
   c_jump: cover property (@(posedge i_core_clk) disable iff (i_rst) is_jump);
   c_wrap: cover property (@(posedge i_core_clk) disable iff (i_rst) is_inc && i_reg_rdata == 8'hff);
endmodule : cib_core

// ---- src/cib_regs.svh ----
// Constants for the instruction execution block
`ifndef CIB_REGS_SVH
`define CIB_REGS_SVH
`define CIB_TRAP_VECTOR 11'h001
`define CIB_PC_RESET 11'h000
`define CIB_ACC_RESET 8'h00
`define CIB_TRAP_CYCLES 2'h3
`define CIB_JUMP_CYCLES 2'h2
`define CIB_SKIP_CYCLES 2'h2
`define CIB_ONE_CYCLE 2'h1
`define CIB_REG_ADDR_MAX 7'h7f
`endif

// ---- src/cib_pkg.sv ----
// Types for the instruction execution block
package cib_pkg;
   typedef enum logic [2:0]
   {
      CIB_OP_NOP,
      CIB_OP_GLOBAL_IRQ_ON,
      CIB_OP_ADD_ONE_TO_REGISTER,
      CIB_OP_ADD_ONE_SKIP_ON_ZERO,
      CIB_OP_JUMP_VIA_ACCUMULATOR,
      CIB_OP_SOFTWARE_TRAP,
      CIB_OP_OR_IMMEDIATE_INTO_ACCUMULATOR
   } cib_op_type;
   typedef struct packed
   {
      cib_op_type op;
      logic [6:0] reg_addr;
      logic dest_reg;
      logic [7:0] imm;
   } cib_instr_type;
   typedef struct packed
   {
      logic we;
      logic [6:0] addr;
      logic [7:0] data;
   } cib_rf_write_type;
   typedef struct packed
   {
      logic push;
      logic [10:0] ret_addr;
   } cib_stack_push_type;
endpackage : cib_pkg

// ---- src/cib_alu.sv ----
// Increment and OR datapath with zero detect
`timescale 1ns/10ps
`include "cib_regs.svh"
module cib_alu
   import cib_pkg::*;
(
   // Operands
   input wire logic [7:0] i_reg_data,
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_imm,
   input wire logic i_sel_or,
   // Result
   output logic [7:0] o_result,
   output logic o_zero
);
   // Increment wraps naturally at eight bits
   wire logic [7:0] inc_value = 8'(i_reg_data + 8'h01);
   wire logic [7:0] or_value = i_acc | i_imm;
   assign o_result = i_sel_or ? or_value : inc_value;
   assign o_zero = (o_result == 8'h00);
endmodule : cib_alu

// ---- testbench/cib_rf_model.sv ----
// Register file model answering reads in the same cycle
`timescale 1ns/10ps
module cib_rf_model
   import cib_pkg::*;
(
   // Clock
   input wire logic i_core_clk,
   // Read port
   input wire logic [6:0] i_addr,
   output logic [7:0] o_rdata,
   // Write port
   input wire cib_rf_write_type i_wr
);
   logic [7:0] mem [128];
   // Combinational read, since the core adds one in the same cycle
   assign o_rdata = mem[i_addr];
   // Store one byte per write strobe
   always @(posedge i_core_clk)
   begin
      if (i_wr.we === 1'b1)
      begin
         mem[i_wr.addr] <= i_wr.data;
      end
   end
endmodule : cib_rf_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the instruction execution core
`timescale 1ns/10ps
`define CIB_CHECK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_top
   import cib_pkg::*;
;
   typedef struct packed {logic [7:0] acc; logic z; logic g; logic [10:0] pc; logic rd; logic fl; logic pu;
      logic [10:0] ret; logic we; logic [6:0] wa; logic [7:0] wd;} cib_tb_exp_type;
   logic i_core_clk;
   logic i_rst;
   logic i_instr_valid;
   cib_instr_type i_instr;
   logic [7:0] i_reg_rdata;
   logic [7:0] i_table_page_high;
   cib_rf_write_type o_rf_write;
   cib_stack_push_type o_stack_push;
   logic [7:0] o_acc;
   logic o_zero_flag;
   logic o_global_irq_enable_flag;
   logic [10:0] o_pc;
   logic o_ready;
   logic o_flush;
   cib_tb_exp_type q[$];
   cib_tb_exp_type m;
   cib_tb_exp_type a;
   cib_tb_exp_type s;
   int err_count;
   int num_checks;
   int cyc;
   int lw;
   logic tk;
   int dop[9] = '{1, 2, 6, 3, 3, 4, 5, 5, 2};
   logic [7:0] dv[9] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h10, 8'h00, 8'h00, 8'h00, 8'h7f};
   logic [8:0] dd = 9'b100001000;
   cib_core dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .i_reg_rdata(i_reg_rdata), .i_table_page_high(i_table_page_high), .o_rf_write(o_rf_write),
      .o_stack_push(o_stack_push), .o_acc(o_acc), .o_zero_flag(o_zero_flag),
      .o_global_irq_enable_flag(o_global_irq_enable_flag), .o_pc(o_pc), .o_ready(o_ready), .o_flush(o_flush));
   cib_rf_model rf_u (.i_core_clk(i_core_clk), .i_addr(i_instr.reg_addr), .o_rdata(i_reg_rdata), .i_wr(o_rf_write));
   // Free-running core clock
   initial
   begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   // Hang guard and take tracking; a run stays under about 200 cycles
   always @(posedge i_core_clk)
   begin
      cyc++;
      tk <= i_instr_valid & o_ready;
      if (cyc == 2000)
      begin
         err_count++;
         end_sim();
      end
   end
   // Oldest note is compared one cycle after each take, when pulses stand
   always @(negedge i_core_clk)
   begin
      if (tk === 1'b1 && q.size() > 0)
      begin
         m = q.pop_front();
         a = {o_acc, o_zero_flag, o_global_irq_enable_flag, o_pc, o_ready, o_flush, o_stack_push.push,
            m.pu ? o_stack_push.ret_addr : 11'h000, o_rf_write.we, m.we ? o_rf_write.addr : 7'h00,
            m.we ? o_rf_write.data : 8'h00};
         `CIB_CHECK(a, m)
      end
   end
   // Hold one instruction until taken, noting what it must produce
   task automatic issue(input cib_op_type op, input logic [7:0] val, input logic [7:0] imm, input logic d);
      cib_instr_type ins;
      cib_tb_exp_type e;
      logic [7:0] r;
      int n;
      ins = '{op, 7'($urandom), d, imm};
      i_instr_valid <= 1'b1;
      i_instr <= ins;
      i_table_page_high <= 8'($urandom);
      n = 0;
      @(negedge i_core_clk);
      while (o_ready !== 1'b1 && n < 9)
      begin
         n++;
         @(negedge i_core_clk);
      end
      `CIB_CHECK(n, lw)
      rf_u.mem[ins.reg_addr] = val;
      #1;
      // Expected sum comes from the stored value, not from the model's read port
      r = val + 8'h01;
      e = s;
      {e.rd, e.fl, e.pu, e.ret, e.we, e.wa, e.wd} = {3'b100, 11'h000, 16'h0000};
      e.pc = s.pc + 11'h001;
      lw = 0;
      case (op)
         CIB_OP_GLOBAL_IRQ_ON: e.g = 1'b1;
         CIB_OP_ADD_ONE_TO_REGISTER, CIB_OP_ADD_ONE_SKIP_ON_ZERO:
         begin
            if (d)
               {e.we, e.wa, e.wd} = {1'b1, ins.reg_addr, r};
            else
               e.acc = r;
            e.z = (r == 8'h00);
            if (op == CIB_OP_ADD_ONE_SKIP_ON_ZERO && r == 8'h00)
            begin
               {e.fl, e.rd, e.pc, lw} = {2'b10, 11'(s.pc + 11'h002), 32'd1};
            end
         end
         CIB_OP_JUMP_VIA_ACCUMULATOR: {e.pc, e.rd, lw} = {i_table_page_high[2:0], s.acc, 1'b0, 32'd1};
         CIB_OP_SOFTWARE_TRAP: {e.pu, e.ret, e.pc, e.rd, lw} = {1'b1, 11'(s.pc + 11'h001), 11'h001, 1'b0, 32'd2};
         CIB_OP_OR_IMMEDIATE_INTO_ACCUMULATOR: {e.acc, e.z} = {s.acc | imm, (s.acc | imm) == 8'h00};
         default: ;
      endcase
      q.push_back(e);
      s = e;
      @(posedge i_core_clk);
   endtask : issue
   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   // Directed wraps, skips and traps back to back, then random traffic
   initial
   begin
      {i_rst, i_instr_valid, i_instr, i_table_page_high} = {2'b10, 19'h00000, 8'h00};
      {err_count, num_checks, cyc, lw, tk, s} = '0;
      void'($urandom(32'hc117));
      for (int k = 0; k < 128; k++)
         rf_u.mem[k] = 8'($urandom);
      repeat (3) @(posedge i_core_clk);
      i_rst <= 1'b0;
      for (int k = 0; k < 9; k++)
         issue(cib_op_type'(dop[k]), dv[k], 8'h00, dd[k]);
      $display("directed test done");
      repeat (60)
         issue(cib_op_type'($urandom_range(6)), 8'($urandom), 8'($urandom), 1'($urandom));
      i_instr_valid <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      // Every noted result must have been compared by now
      `CIB_CHECK(q.size(), 0)
      $display("random test done");
      end_sim();
   end
endmodule : tb_top
